// [hdl/qtc_reload_timer.sv]
`timescale 1ns/1ps
// ==========================================================
// 16-bit auto-reload timer, splittable into two 8-bit halves
// ==========================================================
module qtc_reload_timer
	import qtc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	qtc_tmr_if.timer tif
);
	logic [15:0] count_reg;
	logic [15:0] reload_reg;
	logic ovf_lo_reg;
	logic ovf_hi_reg;
	logic lo_full;
	logic hi_full;
	logic step;

	// shared terms
	assign lo_full = count_reg[7:0] == 8'hff;
	assign hi_full = count_reg[15:8] == 8'hff;
	assign step = tif.run && tif.tick && !tif.cnt_wr;

	// reload value, byte lanes honoured
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			reload_reg <= CNT_RST;
		else if (tif.rld_wr)
			reload_reg <= (reload_reg & ~tif.wmask) | (tif.wdata & tif.wmask);
	end

	// count; a software write beats a tick in the same cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_reg <= CNT_RST;
		else if (tif.cnt_wr)
			count_reg <= (count_reg & ~tif.wmask) | (tif.wdata & tif.wmask);
		else if (step && tif.split)
		begin
			count_reg[7:0] <= lo_full ? reload_reg[7:0] : count_reg[7:0] + 8'h01;
			count_reg[15:8] <= hi_full ? reload_reg[15:8] : count_reg[15:8] + 8'h01;
		end
		else if (step)
			count_reg <= (lo_full && hi_full) ? reload_reg : count_reg + 16'h0001;
	end

	// one-cycle overflow pulses, also usable as a time base
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ovf_lo_reg <= 1'b0;
			ovf_hi_reg <= 1'b0;
		end
		else
		begin
			ovf_lo_reg <= step && tif.split && lo_full;
			ovf_hi_reg <= step && hi_full && (tif.split || lo_full);
		end
	end

	assign tif.count = count_reg;
	assign tif.reload = reload_reg;
	assign tif.ovf_lo = ovf_lo_reg;
	assign tif.ovf_hi = ovf_hi_reg;
endmodule : qtc_reload_timer

// [hdl/qtc_timer_unit.sv]
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
// Contract
// - two 16-bit counter/timers behaving like the classic timer pair
// - two more 16-bit auto-reload timers, also giving time base pulses
// - timers 0/1: 13-bit, 16-bit, 8-bit reload; split 8-bit on timer 0 only
// - timers 2/3 run as one 16-bit or two 8-bit auto-reload timers
// - timers 0/1 clock from five sources via select bit and prescale field
// - each of timers 0/1 counts the prescaled clock or the system clock
// - timers 2/3 clock from system, system/12 or external oscillator/8
// - counter mode increments once per falling edge on the count pin
// - count pin events up to a quarter of system clock are counted
// - timers 0/1 count held as separately reachable low and high bytes
// - shared control register holds run enables and overflow flags
// - overflow interrupt only when that timer's enable bit is set
// - mode register has independent mode bits per timer
// - 13-bit mode: high byte upper bits, low byte bits 4..0 lower bits
// - 13-bit wrap from all ones sets overflow flag and may interrupt
module qtc_timer_unit
	import qtc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic count_input_pin_0,
	input wire logic count_input_pin_1,
	input wire logic ext_osc_clk,
	output logic [1:0] time_base_pulse,
	output logic irq
);
	// ==========================================================
	// declarations
	// ==========================================================
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic aw_hold_reg, w_hold_reg, irq_reg;
	logic [1:0] bresp_reg, rresp_reg, time_base_reg;
	logic [31:0] rdata_reg, rd_mux;
	logic [7:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_fire, wr_lo, rd_fire;
	logic [15:0] wmask;
	logic [7:0] timer_ctrl_reg, timer_mode_reg;
	logic [3:0] clk_reg;
	logic [ST_W-1:0] irq_enable_reg, status_reg, status_set;
	logic [3:0] rt_ctrl_reg [2];
	logic [2:0] sync1_reg, sync2_reg, sync3_reg, level_reg;
	logic [2:0] agree, pin_fall, pin_rise;
	logic [5:0] div_cnt_reg [3];
	logic [2:0] div_tick;
	logic [2:0] ext_cnt_reg;
	logic ext_tick, pre_tick;
	logic [7:0] tl_reg [2];
	logic [7:0] th_reg [2];
	logic [1:0] ovf_a, ovf_b;
	logic [15:0] rt_count [2];
	logic [15:0] rt_reload [2];
	logic [1:0] rt_ovf_lo, rt_ovf_hi;
	logic [1:0] tf_set;
	qtc_mode_t t0_mode, t1_mode;

	assign t0_mode = qtc_mode_t'(timer_mode_reg[MODE_T0_LSB +: 2]);
	assign t1_mode = qtc_mode_t'(timer_mode_reg[MODE_T1_LSB +: 2]);

	// ==========================================================
	// axi4-lite write channel
	// ==========================================================
	assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign wr_lo = wr_fire && wstrb_reg[0];
	assign wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

	// address and data are taken independently, in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_reg <= 1'b0;
			aw_hold_reg <= 1'b0;
			waddr_reg <= 8'h00;
		end
		else if (awready_reg && s_axi_awvalid)
		begin
			awready_reg <= 1'b0;
			aw_hold_reg <= 1'b1;
			waddr_reg <= s_axi_awaddr;
		end
		else if (bvalid_reg && s_axi_bready)
			aw_hold_reg <= 1'b0;
		else if (!aw_hold_reg)
			awready_reg <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wready_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
		end
		else if (wready_reg && s_axi_wvalid)
		begin
			wready_reg <= 1'b0;
			w_hold_reg <= 1'b1;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
		end
		else if (bvalid_reg && s_axi_bready)
			w_hold_reg <= 1'b0;
		else if (!w_hold_reg)
			wready_reg <= 1'b1;
	end

	// response one cycle after both halves are held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (waddr_reg > OFS_LAST || waddr_reg[1:0] != 2'h0) ?
				RESP_SLVERR : RESP_OKAY;
		end
		else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	// ==========================================================
	// axi4-lite read channel
	// ==========================================================
	assign rd_fire = arready_reg && s_axi_arvalid;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
			OFS_CTRL: rd_mux[7:0] = timer_ctrl_reg;
			OFS_MODE: rd_mux[7:0] = timer_mode_reg;
			OFS_CLKSEL: rd_mux[3:0] = clk_reg;
			OFS_IRQ_EN: rd_mux[ST_W-1:0] = irq_enable_reg;
			OFS_STATUS: rd_mux[ST_W-1:0] = status_reg;
			OFS_T0_LO: rd_mux[7:0] = tl_reg[0];
			OFS_T0_HI: rd_mux[7:0] = th_reg[0];
			OFS_T1_LO: rd_mux[7:0] = tl_reg[1];
			OFS_T1_HI: rd_mux[7:0] = th_reg[1];
			OFS_RT_CTRL[0]: rd_mux[3:0] = rt_ctrl_reg[0];
			OFS_RT_CNT[0]: rd_mux[15:0] = rt_count[0];
			OFS_RT_RLD[0]: rd_mux[15:0] = rt_reload[0];
			OFS_RT_CTRL[1]: rd_mux[3:0] = rt_ctrl_reg[1];
			OFS_RT_CNT[1]: rd_mux[15:0] = rt_count[1];
			OFS_RT_RLD[1]: rd_mux[15:0] = rt_reload[1];
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// data is captured at the address handshake and shown next cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= (s_axi_araddr > OFS_LAST || s_axi_araddr[1:0] != 2'h0) ?
				RESP_SLVERR : RESP_OKAY;
		end
		else if (rvalid_reg && s_axi_rready)
			rvalid_reg <= 1'b0;
		else if (!rvalid_reg)
			arready_reg <= 1'b1;
	end

	// ==========================================================
	// software registers
	// ==========================================================
	// run enables from software; hardware overflow wins over a clearing write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			timer_ctrl_reg <= CTRL_RST;
		else
		begin
			if (wr_lo && waddr_reg == OFS_CTRL)
				timer_ctrl_reg <= {wdata_reg[7:4], 4'h0};
			if (tf_set[0])
				timer_ctrl_reg[CTRL_TF0] <= 1'b1;
			if (tf_set[1])
				timer_ctrl_reg[CTRL_TF1] <= 1'b1;
		end
	end

	// mode and clock selection, one mode field group per timer, one shared prescale field
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_mode_reg <= MODE_RST;
			clk_reg <= CLK_RST;
			irq_enable_reg <= ST_RST;
		end
		else if (wr_lo)
		begin
			if (waddr_reg == OFS_MODE)
				timer_mode_reg <= wdata_reg[7:0];
			if (waddr_reg == OFS_CLKSEL)
				clk_reg <= wdata_reg[3:0];
			if (waddr_reg == OFS_IRQ_EN)
				irq_enable_reg <= wdata_reg[ST_W-1:0];
		end
	end

	// sticky status, cleared by reading it; a same-cycle event survives
	assign status_set = {rt_ovf_lo[1], rt_ovf_hi[1], rt_ovf_lo[0], rt_ovf_hi[0], tf_set};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			status_reg <= ST_RST;
		else if (rd_fire && s_axi_araddr == OFS_STATUS)
			status_reg <= status_set;
		else
			status_reg <= status_reg | status_set;
	end

	// one level interrupt; masked bits never reach it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_reg <= 1'b0;
		else
			irq_reg <= |(status_reg & irq_enable_reg);
	end

	// ==========================================================
	// pin sampling and clock sources
	// ==========================================================
	// three stages; the first stage feeds only the second
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_reg <= 3'h7;
			sync2_reg <= 3'h7;
			sync3_reg <= 3'h7;
			level_reg <= 3'h7;
		end
		else
		begin
			sync1_reg <= {ext_osc_clk, count_input_pin_1, count_input_pin_0};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			level_reg <= (level_reg & ~agree) | (sync3_reg & agree);
		end
	end

	// a new level counts once two stages agree; needs the pin held two clocks
	assign agree = ~(sync2_reg ^ sync3_reg);
	assign pin_fall = level_reg & agree & ~sync3_reg;
	assign pin_rise = ~level_reg & agree & sync3_reg;

	// free-running system clock dividers
	for (genvar k = 0; k < 3; k++)
	begin : g_div
		always_ff @(posedge aclk)
		begin
			if (!aresetn || div_tick[k])
				div_cnt_reg[k] <= 6'h00;
			else
				div_cnt_reg[k] <= div_cnt_reg[k] + 6'h01;
		end
		assign div_tick[k] = div_cnt_reg[k] == 6'(DIV_TAB[k] - 1);
	end

	// external oscillator divided by eight, counted on its sampled edges
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ext_cnt_reg <= 3'h0;
		else if (pin_rise[2])
			ext_cnt_reg <= ext_cnt_reg + 3'h1;
	end
	assign ext_tick = pin_rise[2] && ext_cnt_reg == EXT_DIV_LAST;

	// shared prescaled clock for timers 0 and 1
	always_comb
	begin
		case (qtc_pre_t'(clk_reg[CLK_SCA_LSB +: 2]))
			QTC_PRE12: pre_tick = div_tick[DIV_IDX12];
			QTC_PRE4: pre_tick = div_tick[DIV_IDX4];
			QTC_PRE48: pre_tick = div_tick[DIV_IDX48];
			default: pre_tick = ext_tick;
		endcase
	end

	// ==========================================================
	// timers 0 and 1
	// ==========================================================
	// timer 1 overflow cannot flag while timer 0 borrows its flag in split mode
	assign tf_set[0] = ovf_a[0];
	assign tf_set[1] = (ovf_a[1] && t0_mode != QTC_MSPLIT) || ovf_b[0];

	for (genvar i = 0; i < 2; i++)
	begin : g_ct
		qtc_mode_t mode;
		logic sys_tick, tick, run_lo, run_hi, hi_wrap;
		logic [7:0] lo_n, hi_n;
		assign mode = (i == 0) ? t0_mode : t1_mode;
		assign sys_tick = clk_reg[CLK_T0_SYS + i] ? 1'b1 : pre_tick;
		assign tick = timer_mode_reg[MODE_T0_CNT + 4 * i] ? pin_fall[i] : sys_tick;
		// timer 1 holds in split mode; timer 0 high half borrows run 1
		assign run_lo = timer_ctrl_reg[CTRL_RUN0 + 2 * i] && tick &&
			!(i == 1 && mode == QTC_MSPLIT);
		assign run_hi = i == 0 && mode == QTC_MSPLIT && timer_ctrl_reg[CTRL_RUN1] && sys_tick;

		always_comb
		begin
			lo_n = tl_reg[i];
			hi_n = th_reg[i];
			ovf_a[i] = 1'b0;
			hi_wrap = 1'b0;
			if (run_lo)
			begin
				case (mode)
					QTC_M13:
					begin
						{hi_n, lo_n[4:0]} = {th_reg[i], tl_reg[i][4:0]} + 13'h0001;
						ovf_a[i] = &{th_reg[i], tl_reg[i][4:0]};
					end
					QTC_M16:
					begin
						{hi_n, lo_n} = {th_reg[i], tl_reg[i]} + 16'h0001;
						ovf_a[i] = &{th_reg[i], tl_reg[i]};
					end
					QTC_M8R:
					begin
						lo_n = (&tl_reg[i]) ? th_reg[i] : tl_reg[i] + 8'h01;
						ovf_a[i] = &tl_reg[i];
					end
					default:
					begin
						lo_n = tl_reg[i] + 8'h01;
						ovf_a[i] = &tl_reg[i];
					end
				endcase
			end
			if (run_hi)
			begin
				hi_n = th_reg[i] + 8'h01;
				hi_wrap = &th_reg[i];
			end
		end
		assign ovf_b[i] = hi_wrap;

		// byte writes land at once and beat a count in the same cycle
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				tl_reg[i] <= BYTE_RST;
				th_reg[i] <= BYTE_RST;
			end
			else
			begin
				tl_reg[i] <= (wr_lo && waddr_reg == OFS_T0_LO + 8'(8 * i)) ?
					wdata_reg[7:0] : lo_n;
				th_reg[i] <= (wr_lo && waddr_reg == OFS_T0_HI + 8'(8 * i)) ?
					wdata_reg[7:0] : hi_n;
			end
		end
	end

	// ==========================================================
	// timers 2 and 3
	// ==========================================================
	for (genvar j = 0; j < 2; j++)
	begin : g_rt
		qtc_tmr_if tif();
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				rt_ctrl_reg[j] <= RT_CTRL_RST;
			else if (wr_lo && waddr_reg == OFS_RT_CTRL[j])
				rt_ctrl_reg[j] <= wdata_reg[3:0];
		end
		always_comb
		begin
			case (qtc_src_t'(rt_ctrl_reg[j][RT_SRC_LSB +: 2]))
				QTC_SRC_SYS: tif.tick = 1'b1;
				QTC_SRC_DIV12: tif.tick = div_tick[DIV_IDX12];
				QTC_SRC_EXT8: tif.tick = ext_tick;
				default: tif.tick = 1'b0;
			endcase
		end
		assign tif.run = rt_ctrl_reg[j][RT_RUN];
		assign tif.split = rt_ctrl_reg[j][RT_SPLIT];
		assign tif.cnt_wr = wr_fire && waddr_reg == OFS_RT_CNT[j];
		assign tif.rld_wr = wr_fire && waddr_reg == OFS_RT_RLD[j];
		assign tif.wdata = wdata_reg[15:0];
		assign tif.wmask = wmask;
		assign rt_count[j] = tif.count;
		assign rt_reload[j] = tif.reload;
		assign rt_ovf_lo[j] = tif.ovf_lo;
		assign rt_ovf_hi[j] = tif.ovf_hi;
		qtc_reload_timer u_rt (
			.aclk(aclk),
			.aresetn(aresetn),
			.tif(tif)
		);
	end

	// registered time base pulses for other blocks
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			time_base_reg <= 2'h0;
		else
			time_base_reg <= rt_ovf_hi;
	end

	// ==========================================================
	// outputs
	// ==========================================================
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign time_base_pulse = time_base_reg;
	assign irq = irq_reg;
endmodule : qtc_timer_unit

// [pkg/qtc_pkg.sv]
// ==========================================================
// shared constants of the quad timer counter unit
// ==========================================================
package qtc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_CLKSEL = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_T0_LO = 8'h14;
	localparam logic [7:0] OFS_T0_HI = 8'h18;
	localparam logic [7:0] OFS_T1_LO = 8'h1c;
	localparam logic [7:0] OFS_T1_HI = 8'h20;
	localparam logic [7:0] OFS_LAST = 8'h38;
	localparam logic [7:0] OFS_RT_CTRL [2] = '{8'h24, 8'h30};
	localparam logic [7:0] OFS_RT_CNT [2] = '{8'h28, 8'h34};
	localparam logic [7:0] OFS_RT_RLD [2] = '{8'h2c, 8'h38};
	// timer_ctrl_reg fields
	localparam int CTRL_TF1 = 7;
	localparam int CTRL_RUN1 = 6;
	localparam int CTRL_TF0 = 5;
	localparam int CTRL_RUN0 = 4;
	// timer_mode_reg fields: two mode bits and a counter select per timer
	localparam int MODE_T0_LSB = 0;
	localparam int MODE_T0_CNT = 2;
	localparam int MODE_T1_LSB = 4;
	localparam int MODE_T1_CNT = 6;
	// clock select register fields
	localparam int CLK_SCA_LSB = 0;
	localparam int CLK_T0_SYS = 2;
	localparam int CLK_T1_SYS = 3;
	// reload timer control fields
	localparam int RT_RUN = 0;
	localparam int RT_SPLIT = 1;
	localparam int RT_SRC_LSB = 2;
	// status and mask layout
	localparam int ST_W = 6;
	localparam int ST_T0 = 0;
	localparam int ST_T1 = 1;
	localparam int ST_RT_HI [2] = '{2, 4};
	localparam int ST_RT_LO [2] = '{3, 5};
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [3:0] CLK_RST = 4'h0;
	localparam logic [3:0] RT_CTRL_RST = 4'h0;
	localparam logic [5:0] ST_RST = 6'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [15:0] CNT_RST = 16'h0000;
	// clock divisors in system clock cycles: sys/4, sys/12, sys/48
	localparam int DIV_TAB [3] = '{4, 12, 48};
	localparam int DIV_IDX4 = 0;
	localparam int DIV_IDX12 = 1;
	localparam int DIV_IDX48 = 2;
	localparam logic [2:0] EXT_DIV_LAST = 3'h7;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {QTC_M13, QTC_M16, QTC_M8R, QTC_MSPLIT} qtc_mode_t;
	typedef enum logic [1:0] {QTC_PRE12, QTC_PRE4, QTC_PRE48, QTC_PREEXT} qtc_pre_t;
	typedef enum logic [1:0] {QTC_SRC_SYS, QTC_SRC_DIV12, QTC_SRC_EXT8, QTC_SRC_OFF} qtc_src_t;
endpackage : qtc_pkg

// [pkg/qtc_tmr_if.sv]
`timescale 1ns/1ps
// ==========================================================
// link between the unit and one auto-reload timer
// ==========================================================
interface qtc_tmr_if;
	logic run;
	logic split;
	logic tick;
	logic cnt_wr;
	logic rld_wr;
	logic [15:0] wdata;
	logic [15:0] wmask;
	logic [15:0] count;
	logic [15:0] reload;
	logic ovf_lo;
	logic ovf_hi;
	modport ctl(output run, split, tick, cnt_wr, rld_wr, wdata, wmask,
		input count, reload, ovf_lo, ovf_hi);
	modport timer(input run, split, tick, cnt_wr, rld_wr, wdata, wmask,
		output count, reload, ovf_lo, ovf_hi);
endinterface : qtc_tmr_if

// [verification/qtc_unit_props.sv]
`timescale 1ns/1ps
// ==========================================================
// bus handshake checks on the unit's top ports
// ==========================================================
module qtc_unit_props
	import qtc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// outside the map or not word aligned
	wire aw_bad = (s_axi_awaddr > OFS_LAST) || (s_axi_awaddr[1:0] != 2'h0);
	wire ar_bad = (s_axi_araddr > OFS_LAST) || (s_axi_araddr[1:0] != 2'h0);
	wire aw_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire ar_go = s_axi_arvalid && s_axi_arready;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// write: one hold cycle, then the answer
	property p_wr_lat;
		aw_go |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	property p_wr_err;
		aw_go && aw_bad |-> ##2 s_axi_bresp == RESP_SLVERR;
	endproperty
	a_wr_err: assert property (p_wr_err) else $error("bad write not refused");
	// readies come back two cycles after the response is taken
	property p_wr_back;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready);
	endproperty
	a_wr_back: assert property (p_wr_back) else $error("write readies stuck");
	property p_wr_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wr_busy: assert property (p_wr_busy) else $error("write taken while busy");
	property p_rd_lat;
		ar_go |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_rd_err;
		ar_go && ar_bad |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("bad read not refused");
	property p_rd_ok;
		ar_go && !ar_bad |=> s_axi_rresp == RESP_OKAY;
	endproperty
	a_rd_ok: assert property (p_rd_ok) else $error("good read refused");
	property p_rd_back;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready;
	endproperty
	a_rd_back: assert property (p_rd_back) else $error("read ready stuck");
	property p_rd_busy;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rd_busy: assert property (p_rd_busy) else $error("read taken while busy");
endmodule : qtc_unit_props

bind qtc_timer_unit qtc_unit_props u_props(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready);

// [verification/test_quad_timer_counter_unit.sv]
`timescale 1ns/1ps
// ==========================================================
// register level test of the quad timer counter unit
// ==========================================================
module test_quad_timer_counter_unit
	import qtc_pkg::*;
;
	logic aclk = 1'h0, aresetn = 1'h0, ext_osc_clk = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [1:0] pins = 2'h3;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, time_base_pulse;
	logic [31:0] s_axi_rdata, v;
	int mismatches = 0, num_checks = 0, cyc = 0, tbp = 0;
	qtc_timer_unit DUT(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_input_pin_0(pins[0]),
		.count_input_pin_1(pins[1]), .ext_osc_clk, .time_base_pulse, .irq);
	// 25 MHz system clock
	always #20 aclk = ~aclk;
	// watchdog, slow oscillator pin stepped on clock edges, time base pulse count
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc % 3 == 0)
			ext_osc_clk <= ~ext_osc_clk;
		tbp += time_base_pulse[0] + 16 * time_base_pulse[1];
		if (cyc == 20000)
		begin
			mismatches++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// write: offer address and data together, release each when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, s_axi_bresp});
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk($sformatf("reg %h", a), exp, d);
		chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, r});
	endtask : rc
	// falling edges at a quarter of the clock, each level held two cycles
	task automatic edges(input int n, input int p);
		repeat (n)
		begin
			pins[p] <= 1'h0;
			repeat (2) @(posedge aclk);
			pins[p] <= 1'h1;
			repeat (2) @(posedge aclk);
		end
		repeat (6) @(posedge aclk);
	endtask : edges
	// main sequence
	initial
	begin
		logic [1:0] r;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rc(OFS_CTRL, 32'h0);
		rc(OFS_MODE, 32'h0);
		rc(OFS_STATUS, 32'h0);
		rc(OFS_T0_HI, 32'h0);
		wr(8'h3c, 32'h1, RESP_SLVERR);
		rc(8'h40, 32'h0, RESP_SLVERR);
		// both timers count pins, 16-bit mode
		wr(OFS_MODE, 32'h55);
		wr(OFS_CTRL, 32'h50);
		edges(5, 0);
		edges(3, 1);
		rc(OFS_T0_LO, 32'h5);
		rc(OFS_T1_LO, 32'h3);
		wr(OFS_T1_HI, 32'ha5);
		rc(OFS_T1_HI, 32'ha5);
		// timer 0 13-bit wrap, timer 1 8-bit reload
		wr(OFS_CTRL, 32'h0);
		wr(OFS_MODE, 32'h64);
		wr(OFS_IRQ_EN, 32'h0);
		wr(OFS_T0_LO, 32'h1f);
		wr(OFS_T0_HI, 32'hff);
		wr(OFS_T1_LO, 32'hfe);
		wr(OFS_T1_HI, 32'hfe);
		wr(OFS_CTRL, 32'h50);
		edges(1, 0);
		edges(3, 1);
		rc(OFS_CTRL, 32'hf0);
		rc(OFS_T0_HI, 32'h0);
		rc(OFS_T0_LO, 32'h0);
		rc(OFS_T1_LO, 32'hff);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(OFS_IRQ_EN, 32'h1);
		repeat (3) @(posedge aclk);
		chk("irq enabled", 32'h1, {31'h0, irq});
		rc(OFS_STATUS, 32'h3);
		repeat (3) @(posedge aclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rc(OFS_STATUS, 32'h0);
		// timer 0 split: low byte wraps alone
		wr(OFS_CTRL, 32'h0);
		wr(OFS_MODE, 32'h07);
		wr(OFS_T0_LO, 32'hfe);
		wr(OFS_T0_HI, 32'h12);
		wr(OFS_CTRL, 32'h10);
		edges(2, 0);
		rc(OFS_T0_LO, 32'h0);
		rc(OFS_T0_HI, 32'h12);
		rc(OFS_STATUS, 32'h1);
		// system clock against the slowest prescale
		wr(OFS_CTRL, 32'h0);
		wr(OFS_MODE, 32'h01);
		wr(OFS_CLKSEL, 32'h4);
		wr(OFS_T0_LO, 32'h0);
		wr(OFS_CTRL, 32'h10);
		repeat (40) @(posedge aclk);
		wr(OFS_CTRL, 32'h0);
		rd(OFS_T0_LO, v, r);
		chk("t0 sysclk", 32'h1, {31'h0, v > 32'd40});
		wr(OFS_CLKSEL, 32'h2);
		wr(OFS_T0_LO, 32'h0);
		wr(OFS_CTRL, 32'h10);
		repeat (40) @(posedge aclk);
		wr(OFS_CTRL, 32'h0);
		rd(OFS_T0_LO, v, r);
		chk("t0 prescaled", 32'h1, {31'h0, v < 32'd4});
		// timer 2 as one 16-bit reload timer on the system clock
		wr(OFS_RT_RLD[0], 32'h1234);
		rc(OFS_RT_RLD[0], 32'h1234);
		wr(OFS_RT_CNT[0], 32'hfff0);
		wr(OFS_RT_CTRL[0], 32'h1);
		repeat (30) @(posedge aclk);
		wr(OFS_RT_CTRL[0], 32'h0);
		rc(OFS_STATUS, 32'h4);
		chk("time base pulses", 32'h1, tbp);
		// timer 3 split, both halves ticking from the oscillator over eight
		wr(OFS_RT_RLD[1], 32'h1020);
		wr(OFS_RT_CNT[1], 32'hfefd);
		wr(OFS_RT_CTRL[1], 32'hb);
		repeat (200) @(posedge aclk);
		wr(OFS_RT_CTRL[1], 32'h0);
		rc(OFS_STATUS, 32'h30);
		chk("time base pulses t3", 32'h11, tbp);
		close_out();
	end
endmodule : test_quad_timer_counter_unit
